// ### verilog/tfp_pkg.sv
// Functional notes
// RULE_01: fast modes 5,6,7,14,15 count BOTTOM up to TOP, then restart at BOTTOM.
// RULE_02: fast TOP is fixed, capture value, or compare A; clear one tick after TOP.
// RULE_03: fast output mode 2 clears on match, sets at BOTTOM; mode 3 inverse.
// RULE_04: any PWM mode sets channel match flag when count equals its compare value.
// RULE_05: fast overflow flag at TOP; TOP-defining register flag set same tick.
// RULE_06: fixed TOP modes mask compare writes above the resolution to zero.
// RULE_07: capture TOP is unbuffered; missed TOP runs to maximum and wraps through zero.
// RULE_08: fast compare writes buffered; active value loads at TOP with clear and overflow.
// RULE_09: compare zero gives one-tick spike per period; compare TOP gives constant level.
// RULE_10: fast channel A output mode 1 toggles on match, still double buffered.
// RULE_11: compare level reaches pin only when pin direction bit selects output.
// RULE_12: phase modes 1,2,3,10,11 count up to TOP then down to BOTTOM.
// RULE_13: phase TOP fixed, capture value or compare A; TOP held one tick.
// RULE_14: phase non-inverting clears on up match, sets on down match; inverting opposite.
// RULE_15: phase overflow at BOTTOM; buffers load at TOP with TOP register flag.
// RULE_16: software keeps register TOP between 0x0003 and 0xFFFF.
// RULE_17: software keeps TOP at or above compare values, else no match occurs.
// RULE_18: phase compare BOTTOM gives constant low, TOP constant high, non-inverting.
// RULE_19: phase period runs TOP to TOP since compare values load at TOP.
// RULE_20: output mode zero leaves compare output alone; pin returns to port control.
// RULE_21: output mode bits are unbuffered and act at once.
// RULE_22: reset clears every channel's compare output register.
// RULE_23: counting and match evaluation happen only on timer tick cycles.
package tfp_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] TFP_OFF_CTRL = 8'h00;
  localparam logic [7:0] TFP_OFF_COUNT = 8'h04;
  localparam logic [7:0] TFP_OFF_CMPA = 8'h08;
  localparam logic [7:0] TFP_OFF_CMPB = 8'h0C;
  localparam logic [7:0] TFP_OFF_CAPTOP = 8'h10;
  localparam logic [7:0] TFP_OFF_FLAGS = 8'h14;
  localparam logic [7:0] TFP_OFF_ACTIVE = 8'h18;
  // ==========================================================
  // control fields
  localparam int TFP_CTRL_WGM_LSB = 0;
  localparam int TFP_CTRL_COMA_LSB = 4;
  localparam int TFP_CTRL_COMB_LSB = 6;
  localparam int TFP_CTRL_DIR_LSB = 8;
  localparam logic [3:0] TFP_WGM_RST = 4'h0;
  localparam logic [1:0] TFP_COM_RST = 2'h0;
  localparam logic [1:0] TFP_DIR_RST = 2'h0;
  // flag bit positions
  localparam int TFP_FLG_OVF = 0;
  localparam int TFP_FLG_MATCH_A = 1;
  localparam int TFP_FLG_MATCH_B = 2;
  localparam int TFP_FLG_CAP = 3;
  // ==========================================================
  // waveform modes
  localparam logic [3:0] TFP_WGM_PH8 = 4'h1;
  localparam logic [3:0] TFP_WGM_PH9 = 4'h2;
  localparam logic [3:0] TFP_WGM_PH10 = 4'h3;
  localparam logic [3:0] TFP_WGM_FA8 = 4'h5;
  localparam logic [3:0] TFP_WGM_FA9 = 4'h6;
  localparam logic [3:0] TFP_WGM_FA10 = 4'h7;
  localparam logic [3:0] TFP_WGM_PH_CAP = 4'hA;
  localparam logic [3:0] TFP_WGM_PH_CMPA = 4'hB;
  localparam logic [3:0] TFP_WGM_FA_CAP = 4'hE;
  localparam logic [3:0] TFP_WGM_FA_CMPA = 4'hF;
  // output modes
  localparam logic [1:0] TFP_COM_OFF = 2'h0;
  localparam logic [1:0] TFP_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TFP_COM_NONINV = 2'h2;
  localparam logic [1:0] TFP_COM_INV = 2'h3;
  // counter values
  localparam logic [15:0] TFP_BOTTOM = 16'h0000;
  localparam logic [15:0] TFP_MAX = 16'hFFFF;
  localparam logic [15:0] TFP_TOP8 = 16'h00FF;
  localparam logic [15:0] TFP_TOP9 = 16'h01FF;
  localparam logic [15:0] TFP_TOP10 = 16'h03FF;
  localparam logic [15:0] TFP_ONE = 16'h0001;
  localparam logic [15:0] TFP_RST16 = 16'h0000;

  typedef enum logic [0:0] {TFP_DIR_UP = 1'b0, TFP_DIR_DOWN = 1'b1} tfp_dir_t;

  // fixed TOP of a mode, zero when TOP is not fixed; doubles as write mask
  function automatic logic [15:0] tfp_fixed_top(input logic [3:0] wgm);
    logic [15:0] r;
    r = TFP_BOTTOM;
    if (wgm == TFP_WGM_PH8 || wgm == TFP_WGM_FA8) r = TFP_TOP8;
    if (wgm == TFP_WGM_PH9 || wgm == TFP_WGM_FA9) r = TFP_TOP9;
    if (wgm == TFP_WGM_PH10 || wgm == TFP_WGM_FA10) r = TFP_TOP10;
    return r;
  endfunction

  function automatic logic tfp_is_fast(input logic [3:0] wgm);
    return wgm == TFP_WGM_FA8 || wgm == TFP_WGM_FA9 || wgm == TFP_WGM_FA10 ||
           wgm == TFP_WGM_FA_CAP || wgm == TFP_WGM_FA_CMPA;
  endfunction

  function automatic logic tfp_is_phase(input logic [3:0] wgm);
    return wgm == TFP_WGM_PH8 || wgm == TFP_WGM_PH9 || wgm == TFP_WGM_PH10 ||
           wgm == TFP_WGM_PH_CAP || wgm == TFP_WGM_PH_CMPA;
  endfunction
endpackage

// ### verilog/tfp_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tfp_chan_if;
  logic tick;
  logic [15:0] count;
  logic load;
  logic top_clr;
  logic fast;
  logic phase;
  logic rising;
  logic buffered;
  logic wr;
  logic [15:0] wdata;
  logic [1:0] mode;
  logic [15:0] active;
  logic [15:0] buffer;
  logic match;
  logic oc;
  modport ctl (output tick, count, load, top_clr, fast, phase, rising, buffered, wr, wdata, mode,
               input active, buffer, match, oc);
  modport chan (input tick, count, load, top_clr, fast, phase, rising, buffered, wr, wdata, mode,
                output active, buffer, match, oc);
endinterface
`default_nettype wire

// ### verilog/tfp_compare_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tfp_compare_channel #(
  parameter bit CAN_TOGGLE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  tfp_chan_if.chan ch
);
  // ==========================================================
  // compare buffer and active value
  always_ff @(posedge clk) begin
    if (rst) begin
      ch.buffer <= tfp_pkg::TFP_RST16;
    end else if (ch.wr) begin
      ch.buffer <= ch.wdata; // RULE_08
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch.active <= tfp_pkg::TFP_RST16;
    end else if (ch.wr && !ch.buffered) begin
      ch.active <= ch.wdata;
    end else if (ch.load) begin
      ch.active <= ch.buffer; // RULE_08 RULE_15 RULE_19
    end
  end

  assign ch.match = ch.tick && (ch.count == ch.active); // RULE_04 RULE_23

  // ==========================================================
  // compare output register; mode read live, never buffered
  always_ff @(posedge clk) begin
    if (rst) begin
      ch.oc <= 1'b0; // RULE_22
    end else if (ch.tick) begin
      unique case (ch.mode) // RULE_21
        tfp_pkg::TFP_COM_NONINV: begin
          // set at the clear wins, so compare at TOP stays high
          if (ch.fast && ch.top_clr) begin
            ch.oc <= 1'b1; // RULE_03 RULE_09
          end else if (ch.fast && ch.match) begin
            ch.oc <= 1'b0; // RULE_03
          end else if (ch.phase && ch.match) begin
            ch.oc <= !ch.rising; // RULE_14 RULE_18
          end
        end
        tfp_pkg::TFP_COM_INV: begin
          if (ch.fast && ch.top_clr) begin
            ch.oc <= 1'b0; // RULE_03 RULE_09
          end else if (ch.fast && ch.match) begin
            ch.oc <= 1'b1; // RULE_03
          end else if (ch.phase && ch.match) begin
            ch.oc <= ch.rising; // RULE_14 RULE_18
          end
        end
        tfp_pkg::TFP_COM_TOGGLE: begin
          if (CAN_TOGGLE && ch.fast && ch.match) begin
            ch.oc <= !ch.oc; // RULE_10
          end
        end
        tfp_pkg::TFP_COM_OFF: begin
          ch.oc <= ch.oc; // RULE_20
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verilog/tfp_timer_pwm.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module tfp_timer_pwm (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic [1:0] port_level,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);
  // ==========================================================
  // state
  logic [3:0] waveform_mode_select;
  logic [1:0] channel_a_output_mode;
  logic [1:0] channel_b_output_mode;
  logic [1:0] output_pin_direction_bit;
  logic [15:0] counter_value;
  logic [15:0] capture_top_value;
  tfp_pkg::tfp_dir_t count_dir;
  logic overflow_flag;
  logic capture_flag;
  logic [1:0] compare_match_flag;

  logic [15:0] top_value;
  logic [15:0] fixed_top;
  logic is_fast;
  logic is_phase;
  logic at_top;
  logic at_bottom;
  logic rising;
  logic load_evt;
  logic ovf_set;
  logic cap_set;
  logic [1:0] chan_match;
  logic [1:0] chan_oc;
  logic [15:0] act_a;
  logic [15:0] act_b;
  logic [15:0] buf_a;
  logic [15:0] buf_b;
  logic [15:0] cmp_wdata;

  // ==========================================================
  // apb slave: one wait state, pready from a flop
  logic apb_done;
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_cap;
  logic wr_flags;

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == tfp_pkg::TFP_OFF_CTRL || a == tfp_pkg::TFP_OFF_COUNT ||
           a == tfp_pkg::TFP_OFF_CMPA || a == tfp_pkg::TFP_OFF_CMPB ||
           a == tfp_pkg::TFP_OFF_CAPTOP || a == tfp_pkg::TFP_OFF_FLAGS ||
           a == tfp_pkg::TFP_OFF_ACTIVE;
  endfunction

  assign apb_done = psel && penable && pready;
  assign wr_ctrl = apb_done && pwrite && paddr == tfp_pkg::TFP_OFF_CTRL;
  assign wr_count = apb_done && pwrite && paddr == tfp_pkg::TFP_OFF_COUNT;
  assign wr_cmpa = apb_done && pwrite && paddr == tfp_pkg::TFP_OFF_CMPA;
  assign wr_cmpb = apb_done && pwrite && paddr == tfp_pkg::TFP_OFF_CMPB;
  assign wr_cap = apb_done && pwrite && paddr == tfp_pkg::TFP_OFF_CAPTOP;
  assign wr_flags = apb_done && pwrite && paddr == tfp_pkg::TFP_OFF_FLAGS;

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_mapped(paddr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready && !pwrite) begin
      unique case (paddr)
        tfp_pkg::TFP_OFF_CTRL: prdata <= {22'h000000, output_pin_direction_bit, channel_b_output_mode,
                                          channel_a_output_mode, waveform_mode_select};
        tfp_pkg::TFP_OFF_COUNT: prdata <= {16'h0000, counter_value};
        tfp_pkg::TFP_OFF_CMPA: prdata <= {16'h0000, buf_a};
        tfp_pkg::TFP_OFF_CMPB: prdata <= {16'h0000, buf_b};
        tfp_pkg::TFP_OFF_CAPTOP: prdata <= {16'h0000, capture_top_value};
        tfp_pkg::TFP_OFF_FLAGS: prdata <= {28'h0000000, capture_flag, compare_match_flag, overflow_flag};
        tfp_pkg::TFP_OFF_ACTIVE: prdata <= {act_b, act_a};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // control and capture registers
  always_ff @(posedge clk) begin
    if (rst) begin
      waveform_mode_select <= tfp_pkg::TFP_WGM_RST;
      channel_a_output_mode <= tfp_pkg::TFP_COM_RST;
      channel_b_output_mode <= tfp_pkg::TFP_COM_RST;
      output_pin_direction_bit <= tfp_pkg::TFP_DIR_RST;
    end else if (wr_ctrl) begin
      waveform_mode_select <= pwdata[tfp_pkg::TFP_CTRL_WGM_LSB +: 4];
      channel_a_output_mode <= pwdata[tfp_pkg::TFP_CTRL_COMA_LSB +: 2]; // RULE_21
      channel_b_output_mode <= pwdata[tfp_pkg::TFP_CTRL_COMB_LSB +: 2]; // RULE_21
      output_pin_direction_bit <= pwdata[tfp_pkg::TFP_CTRL_DIR_LSB +: 2];
    end
  end

  // unbuffered: a value below the count is missed until the wrap
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_top_value <= tfp_pkg::TFP_RST16;
    end else if (wr_cap) begin
      capture_top_value <= pwdata[15:0]; // RULE_07
    end
  end

  // ==========================================================
  // TOP selection and counter events
  always_comb begin
    fixed_top = tfp_pkg::tfp_fixed_top(waveform_mode_select);
    is_fast = tfp_pkg::tfp_is_fast(waveform_mode_select);
    is_phase = tfp_pkg::tfp_is_phase(waveform_mode_select);
    if (fixed_top != tfp_pkg::TFP_BOTTOM) begin
      top_value = fixed_top; // RULE_02 RULE_13
    end else if (waveform_mode_select == tfp_pkg::TFP_WGM_FA_CAP ||
                 waveform_mode_select == tfp_pkg::TFP_WGM_PH_CAP) begin
      top_value = capture_top_value; // RULE_02 RULE_13
    end else if (waveform_mode_select == tfp_pkg::TFP_WGM_FA_CMPA ||
                 waveform_mode_select == tfp_pkg::TFP_WGM_PH_CMPA) begin
      top_value = act_a; // RULE_02 RULE_13
    end else begin
      top_value = tfp_pkg::TFP_MAX;
    end
  end

  assign at_top = counter_value == top_value;
  assign at_bottom = counter_value == tfp_pkg::TFP_BOTTOM;
  // match at BOTTOM counts as rising, at TOP as falling: keeps extremes constant
  assign rising = (count_dir == tfp_pkg::TFP_DIR_UP && !at_top) || at_bottom; // RULE_18
  assign load_evt = timer_tick && at_top && (is_fast || is_phase); // RULE_08 RULE_15 RULE_19
  assign ovf_set = timer_tick && (is_fast ? at_top : (is_phase ? at_bottom :
                   counter_value == tfp_pkg::TFP_MAX)); // RULE_05 RULE_15
  assign cap_set = timer_tick && at_top && (waveform_mode_select == tfp_pkg::TFP_WGM_FA_CAP ||
                   waveform_mode_select == tfp_pkg::TFP_WGM_PH_CAP); // RULE_05 RULE_15

  // ==========================================================
  // counter; a software write overrides the tick
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_value <= tfp_pkg::TFP_RST16;
      count_dir <= tfp_pkg::TFP_DIR_UP;
    end else if (wr_count) begin
      counter_value <= pwdata[15:0];
    end else if (timer_tick) begin // RULE_23
      if (is_fast) begin
        count_dir <= tfp_pkg::TFP_DIR_UP;
        // past TOP the add wraps through zero naturally
        counter_value <= at_top ? tfp_pkg::TFP_BOTTOM : counter_value + tfp_pkg::TFP_ONE; // RULE_01 RULE_02 RULE_07
      end else if (is_phase) begin // RULE_12
        unique case (count_dir)
          tfp_pkg::TFP_DIR_UP: begin
            if (at_top) begin
              counter_value <= counter_value - tfp_pkg::TFP_ONE; // RULE_13
              count_dir <= tfp_pkg::TFP_DIR_DOWN;
            end else begin
              counter_value <= counter_value + tfp_pkg::TFP_ONE;
            end
          end
          tfp_pkg::TFP_DIR_DOWN: begin
            if (at_bottom) begin
              counter_value <= tfp_pkg::TFP_ONE;
              count_dir <= tfp_pkg::TFP_DIR_UP;
            end else begin
              counter_value <= counter_value - tfp_pkg::TFP_ONE;
            end
          end
        endcase
      end else begin
        count_dir <= tfp_pkg::TFP_DIR_UP;
        counter_value <= counter_value + tfp_pkg::TFP_ONE;
      end
    end
  end

  // ==========================================================
  // flags: write one to clear, a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
      compare_match_flag <= 2'h0;
    end else begin
      overflow_flag <= ovf_set || (overflow_flag && !(wr_flags && pwdata[tfp_pkg::TFP_FLG_OVF])); // RULE_05
      capture_flag <= cap_set || (capture_flag && !(wr_flags && pwdata[tfp_pkg::TFP_FLG_CAP]));
      compare_match_flag[0] <= chan_match[0] ||
        (compare_match_flag[0] && !(wr_flags && pwdata[tfp_pkg::TFP_FLG_MATCH_A])); // RULE_04 RULE_05
      compare_match_flag[1] <= chan_match[1] ||
        (compare_match_flag[1] && !(wr_flags && pwdata[tfp_pkg::TFP_FLG_MATCH_B])); // RULE_04
    end
  end

  // ==========================================================
  // compare channels
  // mask upper bits in fixed TOP modes before they reach the buffer
  assign cmp_wdata = (fixed_top != tfp_pkg::TFP_BOTTOM) ? (pwdata[15:0] & fixed_top) : pwdata[15:0]; // RULE_06

  tfp_chan_if chan_bus [2] ();

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      assign chan_bus[g].tick = timer_tick;
      assign chan_bus[g].count = counter_value;
      assign chan_bus[g].load = load_evt;
      assign chan_bus[g].top_clr = timer_tick && is_fast && at_top;
      assign chan_bus[g].fast = is_fast;
      assign chan_bus[g].phase = is_phase;
      assign chan_bus[g].rising = rising;
      assign chan_bus[g].buffered = is_fast || is_phase;
      assign chan_bus[g].wr = (g == 0) ? wr_cmpa : wr_cmpb;
      assign chan_bus[g].wdata = cmp_wdata;
      assign chan_bus[g].mode = (g == 0) ? channel_a_output_mode : channel_b_output_mode;
      assign chan_match[g] = chan_bus[g].match;
      assign chan_oc[g] = chan_bus[g].oc;
      tfp_compare_channel #(
        .CAN_TOGGLE(g == 0)
      ) u_chan (
        .clk(clk),
        .rst(rst),
        .ch(chan_bus[g])
      );
    end
  endgenerate

  assign act_a = chan_bus[0].active;
  assign act_b = chan_bus[1].active;
  assign buf_a = chan_bus[0].buffer;
  assign buf_b = chan_bus[1].buffer;

  // ==========================================================
  // pins: mode zero hands the pin back to the port
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= 2'h0;
      pin_oe <= 2'h0;
    end else begin
      pin_out[0] <= (channel_a_output_mode != tfp_pkg::TFP_COM_OFF) ? chan_oc[0] : port_level[0]; // RULE_20
      pin_out[1] <= (channel_b_output_mode != tfp_pkg::TFP_COM_OFF) ? chan_oc[1] : port_level[1]; // RULE_20
      pin_oe <= output_pin_direction_bit; // RULE_11
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fast_wrap_a: assert property (timer_tick && is_fast && at_top && !wr_count |=> counter_value == 16'h0000) // RULE_02
    else $error("fast counter did not clear after TOP");
  fast_inc_a: assert property (timer_tick && is_fast && !at_top && !wr_count
    |=> counter_value == 16'($past(counter_value) + 16'h0001)) // RULE_01
    else $error("fast counter did not step up");
  phase_turn_a: assert property (timer_tick && is_phase && count_dir == tfp_pkg::TFP_DIR_UP && at_top && !wr_count
    |=> count_dir == tfp_pkg::TFP_DIR_DOWN && counter_value == 16'($past(counter_value) - 16'h0001)) // RULE_13
    else $error("phase counter did not turn at TOP");
  ovf_fast_a: assert property (timer_tick && is_fast && at_top |=> overflow_flag) // RULE_05
    else $error("overflow flag missing at fast TOP");
  ovf_phase_a: assert property (timer_tick && is_phase && at_bottom |=> overflow_flag) // RULE_15
    else $error("overflow flag missing at phase BOTTOM");
  buffer_load_a: assert property (load_evt && !wr_cmpa |=> act_a == $past(buf_a)) // RULE_08
    else $error("active compare not loaded at TOP");
  match_flag_a: assert property (chan_match[1] |=> compare_match_flag[1]) // RULE_04
    else $error("match flag not set");
  pin_dir_a: assert property (wr_ctrl |=> ##1 pin_oe == $past(output_pin_direction_bit)) // RULE_11
    else $error("pin enable does not follow direction bit");
  fast_set_a: assert property (timer_tick && is_fast && at_top && channel_a_output_mode == tfp_pkg::TFP_COM_NONINV
    |=> chan_oc[0]) // RULE_03
    else $error("non-inverting output not set at BOTTOM");
  mask_write_a: assert property (wr_cmpa && fixed_top != 16'h0000 |=> (buf_a & ~$past(fixed_top)) == 16'h0000) // RULE_06
    else $error("compare write not masked");

  fast_wrap_c: cover property (timer_tick && is_fast && at_top);
  phase_turn_c: cover property (timer_tick && is_phase && at_bottom && count_dir == tfp_pkg::TFP_DIR_DOWN);
  pin_rise_c: cover property (pin_oe[0] && $rose(pin_out[0]));
endmodule
`default_nettype wire

// ### tb/tfp_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// load on the two pwm pins
module tfp_load_model (
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] level
);
  // pull-down: an undriven pin reads low, never the last driven value
  assign level = pin_oe & pin_out;
endmodule
`default_nettype wire

// ### tb/test_tfp_timer_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module test_tfp_timer_pwm;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_tick = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic pready, pslverr, er;
  logic [1:0] port_level = 2'h0, pin_out, pin_oe, lvl;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  tfp_timer_pwm uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
    .port_level(port_level), .pin_out(pin_out), .pin_oe(pin_oe));
  tfp_load_model load (.pin_out(pin_out), .pin_oe(pin_oe), .level(lvl));
  // ==========================================================
  // helpers
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // entered just after a rising edge; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    cmp(q & m, e);
  endtask
  // high cycles of channel A pin over a window
  task automatic hi(input int n, input int e);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (lvl[0] === 1'b1) k++;
    end
    cmp(k, e);
  endtask
  function automatic logic [31:0] cw(input logic [3:0] w, input logic [1:0] m, input logic [1:0] d);
    return {22'h0, d, 2'h0, m, w};
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(tfp_pkg::TFP_OFF_CTRL, 32'hFFFFFFFF, 32'h00000000);
    rd(tfp_pkg::TFP_OFF_ACTIVE, 32'hFFFFFFFF, 32'h00000000);
    rd(8'h1C, 32'hFFFFFFFF, 32'h00000000);
    cmp({31'h0, er}, 32'h00000001);
  endtask
  task automatic t_buffer();
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA8, tfp_pkg::TFP_COM_NONINV, 2'h3));
    wr(tfp_pkg::TFP_OFF_CMPA, 32'h00001280);
    rd(tfp_pkg::TFP_OFF_CMPA, 32'hFFFFFFFF, 32'h00000080);
    rd(tfp_pkg::TFP_OFF_COUNT, 32'hFFFFFFFF, 32'h00000000);
    rd(tfp_pkg::TFP_OFF_ACTIVE, 32'hFFFFFFFF, 32'h00000000);
    wr(tfp_pkg::TFP_OFF_COUNT, 32'h000000FE);
    timer_tick <= 1'b1;
    repeat (6) @(posedge clk);
    rd(tfp_pkg::TFP_OFF_ACTIVE, 32'hFFFFFFFF, 32'h00000080);
    rd(tfp_pkg::TFP_OFF_FLAGS, 32'h0000000F, 32'h00000005);
  endtask
  task automatic t_fast();
    hi(256, 129);
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA8, tfp_pkg::TFP_COM_INV, 2'h3));
    // let one full period pass so the old polarity's level is flushed
    repeat (260) @(posedge clk);
    hi(256, 127);
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA8, tfp_pkg::TFP_COM_NONINV, 2'h3));
    wr(tfp_pkg::TFP_OFF_CMPA, 32'h00000000);
    repeat (300) @(posedge clk);
    hi(256, 1);
    wr(tfp_pkg::TFP_OFF_CMPA, 32'h000000FF);
    repeat (300) @(posedge clk);
    hi(256, 256);
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA8, tfp_pkg::TFP_COM_NONINV, 2'h0));
    hi(256, 0);
  endtask
  task automatic t_port();
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA8, tfp_pkg::TFP_COM_OFF, 2'h3));
    port_level <= 2'h1;
    repeat (4) @(posedge clk);
    hi(16, 16);
    port_level <= 2'h0;
    repeat (4) @(posedge clk);
    hi(16, 0);
  endtask
  // one phase period is 510 ticks with the 8-bit top
  task automatic t_phase(input logic [1:0] m, input logic [31:0] c, input int e);
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_PH8, m, 2'h3));
    wr(tfp_pkg::TFP_OFF_CMPA, c);
    repeat (1100) @(posedge clk);
    hi(510, e);
  endtask
  task automatic t_top_a();
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA_CMPA, tfp_pkg::TFP_COM_TOGGLE, 2'h3));
    wr(tfp_pkg::TFP_OFF_CMPA, 32'h00000003);
    repeat (600) @(posedge clk);
    hi(8, 4);
    wr(tfp_pkg::TFP_OFF_FLAGS, 32'h0000000F);
    repeat (8) @(posedge clk);
    rd(tfp_pkg::TFP_OFF_FLAGS, 32'h0000000F, 32'h00000007);
  endtask
  task automatic t_capture();
    wr(tfp_pkg::TFP_OFF_CTRL, cw(tfp_pkg::TFP_WGM_FA_CAP, tfp_pkg::TFP_COM_OFF, 2'h0));
    wr(tfp_pkg::TFP_OFF_CAPTOP, 32'h00000010);
    wr(tfp_pkg::TFP_OFF_COUNT, 32'h00000020);
    wr(tfp_pkg::TFP_OFF_FLAGS, 32'h0000000F);
    repeat (30) @(posedge clk);
    rd(tfp_pkg::TFP_OFF_FLAGS, 32'h00000008, 32'h00000000);
    wr(tfp_pkg::TFP_OFF_COUNT, 32'h0000FFF0);
    repeat (40) @(posedge clk);
    rd(tfp_pkg::TFP_OFF_FLAGS, 32'h00000008, 32'h00000008);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_buffer();
    t_fast();
    t_port();
    t_phase(tfp_pkg::TFP_COM_NONINV, 32'h00000080, 256);
    t_phase(tfp_pkg::TFP_COM_NONINV, 32'h00000000, 0);
    t_phase(tfp_pkg::TFP_COM_NONINV, 32'h000000FF, 510);
    t_phase(tfp_pkg::TFP_COM_INV, 32'h00000080, 254);
    t_top_a();
    t_capture();
    wrap_up();
  end
endmodule
`default_nettype wire
